// file: logic/rcr_pkg.sv
// Purpose: constants, types and decode helpers for the radio config bank
// Assumes: byte-wide registers, one per aligned 32-bit APB word
// Notes: register index times four gives the byte address
package rcr_pkg;

    localparam int RCR_AW = 12;
    localparam int RCR_DW = 32;
    localparam int RCR_NCFG = 7;
    localparam int RCR_LANE0 = 0;

    function automatic logic [RCR_AW-1:0] rcr_baddr(
        input logic [9:0] idx
    );
        return {idx, 2'b00};
    endfunction : rcr_baddr

    // register indices
    localparam logic [9:0] RCR_IDX_RXS = 10'h030;
    localparam logic [9:0] RCR_IDX_CCA = 10'h03F;
    localparam logic [9:0] RCR_IDX_CHAN = 10'h200;
    localparam logic [9:0] RCR_IDX_VCO = 10'h201;
    localparam logic [9:0] RCR_IDX_PLL = 10'h202;
    localparam logic [9:0] RCR_IDX_TXP = 10'h203;
    localparam logic [9:0] RCR_IDX_BAT = 10'h205;
    localparam logic [9:0] RCR_IDX_FRB = 10'h206;

    localparam logic [RCR_AW-1:0] RCR_A_RXS = rcr_baddr(RCR_IDX_RXS);
    localparam logic [RCR_AW-1:0] RCR_A_CCA = rcr_baddr(RCR_IDX_CCA);
    localparam logic [RCR_AW-1:0] RCR_A_CHAN = rcr_baddr(RCR_IDX_CHAN);
    localparam logic [RCR_AW-1:0] RCR_A_VCO = rcr_baddr(RCR_IDX_VCO);
    localparam logic [RCR_AW-1:0] RCR_A_PLL = rcr_baddr(RCR_IDX_PLL);
    localparam logic [RCR_AW-1:0] RCR_A_TXP = rcr_baddr(RCR_IDX_TXP);
    localparam logic [RCR_AW-1:0] RCR_A_BAT = rcr_baddr(RCR_IDX_BAT);
    localparam logic [RCR_AW-1:0] RCR_A_FRB = rcr_baddr(RCR_IDX_FRB);

    localparam logic [7:0] RCR_RST = 8'h00;

    // implemented bits; reserved bits are never stored
    localparam logic [7:0] RCR_M_FULL = 8'hFF;
    localparam logic [7:0] RCR_M_PLL = 8'h80;
    localparam logic [7:0] RCR_M_TXP = 8'hF8;
    localparam logic [7:0] RCR_M_BAT = 8'hF0;
    localparam logic [7:0] RCR_M_FRB = 8'h98;

    localparam int RCR_CHAN_LO = 4;
    localparam int RCR_OPT_HI = 3;
    localparam int RCR_PLL_BIT = 7;
    localparam int RCR_COARSE_LO = 6;
    localparam int RCR_FINE_LO = 3;
    localparam int RCR_BATTERY_TRIP_LEVEL_LO = 4;
    localparam int RCR_TX_FILTER_ON_BIT = 7;
    localparam int RCR_WAKE_BIT = 4;
    localparam int RCR_BATTERY_MONITOR_ON_BIT = 3;
    localparam int RCR_BATTERY_LOW_FLAG_BIT = 5;

    localparam logic [4:0] RCR_CH_FIRST = 5'h0B;
    localparam logic [11:0] RCR_MHZ_BASE = 12'h965;
    localparam logic [11:0] RCR_MHZ_STEP = 12'h005;
    localparam logic [8:0] RCR_COARSE_TDB = 9'h064;
    localparam logic [1:0] RCR_WAKE_FAST_MS = 2'h1;
    localparam logic [1:0] RCR_WAKE_SLOW_MS = 2'h3;

    typedef enum logic [3:0] {
        RCR_SEL_CCA = 4'h0,
        RCR_SEL_CHAN = 4'h1,
        RCR_SEL_VCO = 4'h2,
        RCR_SEL_PLL = 4'h3,
        RCR_SEL_TXP = 4'h4,
        RCR_SEL_BAT = 4'h5,
        RCR_SEL_FRB = 4'h6,
        RCR_SEL_RXS = 4'h7,
        RCR_SEL_NONE = 4'h8
    } rcr_sel_t;

    typedef struct packed {
        logic [7:0] energy_busy_threshold;
        logic [3:0] channel_code;
        logic [4:0] channel_number;
        logic [11:0] channel_mhz;
        logic [3:0] rf_optimise_field;
        logic [7:0] vco_optimise_field;
        logic synth_enable;
        logic [1:0] tx_atten_coarse;
        logic [2:0] tx_atten_fine;
        logic [8:0] tx_atten_tdb;
        logic tx_filter_on;
        logic fast_wake_recovery;
        logic [1:0] wake_limit_ms;
        logic battery_monitor_on;
        logic [3:0] battery_trip_level;
    } rcr_cfg_t;

    function automatic rcr_sel_t rcr_decode(
        input logic [RCR_AW-1:0] a
    );
        if (a == RCR_A_CCA) return RCR_SEL_CCA;
        else if (a == RCR_A_CHAN) return RCR_SEL_CHAN;
        else if (a == RCR_A_VCO) return RCR_SEL_VCO;
        else if (a == RCR_A_PLL) return RCR_SEL_PLL;
        else if (a == RCR_A_TXP) return RCR_SEL_TXP;
        else if (a == RCR_A_BAT) return RCR_SEL_BAT;
        else if (a == RCR_A_FRB) return RCR_SEL_FRB;
        else if (a == RCR_A_RXS) return RCR_SEL_RXS;
        else return RCR_SEL_NONE;
    endfunction : rcr_decode

    function automatic logic [7:0] rcr_wmask(input rcr_sel_t s);
        case (s)
            RCR_SEL_PLL: return RCR_M_PLL;
            RCR_SEL_TXP: return RCR_M_TXP;
            RCR_SEL_BAT: return RCR_M_BAT;
            RCR_SEL_FRB: return RCR_M_FRB;
            default: return RCR_M_FULL;
        endcase
    endfunction : rcr_wmask

    // fine attenuation in tenths of a dB
    function automatic logic [8:0] rcr_fine_tdb(input logic [2:0] c);
        case (c)
            3'h1: return 9'h005;
            3'h2: return 9'h00C;
            3'h3: return 9'h013;
            3'h4: return 9'h01C;
            3'h5: return 9'h025;
            3'h6: return 9'h031;
            3'h7: return 9'h03F;
            default: return 9'h000;
        endcase
    endfunction : rcr_fine_tdb

    // trip level in hundredths of a volt, zero when undefined
    function automatic logic [8:0] rcr_batt_cv(input logic [3:0] c);
        case (c)
            4'hE: return 9'h15E;
            4'hD: return 9'h14A;
            4'hC: return 9'h140;
            4'hB: return 9'h136;
            4'hA: return 9'h118;
            4'h9: return 9'h10E;
            4'h8: return 9'h104;
            4'h7: return 9'h0FA;
            default: return 9'h000;
        endcase
    endfunction : rcr_batt_cv

endpackage : rcr_pkg

// file: logic/rcr_cca_cmp.sv
// Purpose: clear-channel busy decision from signal strength
// Assumes: rssi_level is synchronous to pclk
// Notes: busy reads low outside an assessment
`timescale 1ns/1ns
module rcr_cca_cmp
    import rcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic cca_active,
    input wire logic [7:0] rssi_level,
    input wire logic [7:0] threshold,
    output logic channel_busy
);

    typedef struct packed {
        logic busy;
    } rcr_cca_state_t;

    rcr_cca_state_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.busy = cca_active && (rssi_level > threshold); // R1
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign channel_busy = st.busy;

    property p_busy;
        @(posedge pclk) disable iff (!presetn)
        ce |=> channel_busy ==
            $past(cca_active && (rssi_level > threshold));
    endproperty
    a_busy: assert property (p_busy) // R1
        else $error("busy decision wrong");

endmodule : rcr_cca_cmp

// file: logic/rcr_batt_mon.sv
// Purpose: battery low-voltage indication and trip level decode
// Assumes: supply_below_trip comes from the analog comparator
// Notes: undefined trip codes never raise the indication
`timescale 1ns/1ns
module rcr_batt_mon
    import rcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic monitor_on,
    input wire logic [3:0] trip_level,
    input wire logic supply_below_trip,
    output logic battery_low_flag,
    output logic [8:0] trip_cv
);

    typedef struct packed {
        logic low;
        logic [8:0] cv;
    } rcr_bat_state_t;

    rcr_bat_state_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.cv = rcr_batt_cv(trip_level); // R10
        // comparator output is meaningless for an undefined level
        next_st.low = monitor_on && supply_below_trip
            && (next_st.cv != '0); // R15
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign battery_low_flag = st.low;
    assign trip_cv = st.cv;

    property p_off_clear;
        @(posedge pclk) disable iff (!presetn)
        (ce && !monitor_on) |=> !battery_low_flag;
    endproperty
    a_off_clear: assert property (p_off_clear) // R15
        else $error("low flag set while monitor off");

    property p_trip_35;
        @(posedge pclk) disable iff (!presetn)
        (ce && trip_level == 4'hE) |=> trip_cv == 9'h15E;
    endproperty
    a_trip_35: assert property (p_trip_35) // R10
        else $error("trip level 3.5 V wrong");

endmodule : rcr_batt_mon

// file: logic/rcr_top.sv
// Purpose: APB configuration register bank for a 2.4 GHz radio
// Assumes: APB4 master on pclk, zero-wait answers, byte lane 0 only
// Notes: all state freezes while ce is low, bus answers included
//
// Register access over APB was decided locally.
`timescale 1ns/1ns

// Behaviour
// [R1] channel is busy during assessment when strength exceeds threshold
// [R2] energy threshold resets to zero; software should load 0x60
// [R3] channel code 0..15 selects channel 11..26, 2405 MHz plus 5 per step
// [R4] rf optimise field resets to zero; software should write 0x3
// [R5] vco optimise field resets to zero; software should write 0x2
// [R6] pll enable bit resets off; software sets it before radio use
// [R7] software writes zero to all reserved bits
// [R8] coarse power code gives 0, 10, 20 or 30 dB attenuation
// [R9] fine power code gives 0 to 6.3 dB attenuation per table
// [R10] battery trip code selects 2.5 V to 3.5 V, low codes undefined
// [R11] battery low flag reads as bit 5 of receive status
// [R12] battery monitor enable bit resets off
// [R13] transmit filter bit resets to zero; software should set it
// [R14] wake recovery bit picks 1 ms when set, 3 ms when clear
// [R15] enabled monitor raises low flag under threshold, off holds it clear
module rcr_top
    import rcr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [RCR_AW-1:0] paddr,
    input wire logic [RCR_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [RCR_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cca_active,
    input wire logic [7:0] rssi_level,
    input wire logic supply_below_trip,
    output rcr_cfg_t cfg,
    output logic channel_busy,
    output logic battery_low_flag,
    output logic [8:0] battery_trip_cv
);

    typedef struct packed {
        logic [RCR_NCFG-1:0][7:0] bank;
        logic [RCR_DW-1:0] rdata;
        logic rdy;
        logic err;
        rcr_cfg_t cfg;
    } rcr_state_t;

    rcr_state_t st, next_st;
    rcr_sel_t sel;
    logic setup_ph;
    logic access_ph;
    logic wr_ok;
    logic [7:0] r_chan;
    logic [7:0] r_txp;
    logic [7:0] r_frb;

    function automatic rcr_cfg_t rcr_fields(
        input logic [RCR_NCFG-1:0][7:0] b
    );
        rcr_cfg_t c;
        logic [7:0] ch;
        logic [7:0] tp;
        logic [7:0] fr;
        ch = b[RCR_SEL_CHAN];
        tp = b[RCR_SEL_TXP];
        fr = b[RCR_SEL_FRB];
        c = '0;
        c.energy_busy_threshold = b[RCR_SEL_CCA];
        c.channel_code = ch[RCR_CHAN_LO +: 4];
        c.channel_number = RCR_CH_FIRST + 5'(c.channel_code); // R3
        c.channel_mhz = RCR_MHZ_BASE
            + 12'(RCR_MHZ_STEP * 12'(c.channel_code)); // R3
        c.rf_optimise_field = ch[RCR_OPT_HI:0]; // R4
        c.vco_optimise_field = b[RCR_SEL_VCO]; // R5
        c.synth_enable = b[RCR_SEL_PLL][RCR_PLL_BIT]; // R6
        c.tx_atten_coarse = tp[RCR_COARSE_LO +: 2];
        c.tx_atten_fine = tp[RCR_FINE_LO +: 3];
        c.tx_atten_tdb = 9'(RCR_COARSE_TDB * 9'(c.tx_atten_coarse))
            + rcr_fine_tdb(c.tx_atten_fine); // R8 R9
        c.tx_filter_on = fr[RCR_TX_FILTER_ON_BIT]; // R13
        c.fast_wake_recovery = fr[RCR_WAKE_BIT];
        c.wake_limit_ms = c.fast_wake_recovery
            ? RCR_WAKE_FAST_MS : RCR_WAKE_SLOW_MS; // R14
        c.battery_monitor_on = fr[RCR_BATTERY_MONITOR_ON_BIT]; // R12
        c.battery_trip_level = b[RCR_SEL_BAT][RCR_BATTERY_TRIP_LEVEL_LO +: 4]; // R10
        return c;
    endfunction : rcr_fields

    always_comb begin
        next_st = st;
        sel = rcr_decode(paddr);
        setup_ph = psel && !penable;
        access_ph = psel && penable && st.rdy;
        // error was latched at setup, so a bad access never writes
        wr_ok = access_ph && pwrite && pstrb[RCR_LANE0] && !st.err;
        next_st.rdy = setup_ph;
        if (setup_ph) begin
            next_st.err = (sel == RCR_SEL_NONE)
                || (pwrite && sel == RCR_SEL_RXS);
            next_st.rdata = '0;
            if (!pwrite) begin
                if (sel == RCR_SEL_RXS) begin
                    next_st.rdata[RCR_BATTERY_LOW_FLAG_BIT] = battery_low_flag; // R11
                end else if (sel != RCR_SEL_NONE) begin
                    next_st.rdata[7:0] = st.bank[sel[2:0]];
                end
            end
        end else begin
            next_st.err = 1'b0;
        end
        if (wr_ok) begin
            // reserved bits dropped here, so they always read zero
            next_st.bank[sel[2:0]] = pwdata[7:0] & rcr_wmask(sel); // R7
        end
        next_st.cfg = rcr_fields(next_st.bank);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0; // R2 R4 R5 R6 R12 R13
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign cfg = st.cfg;

    rcr_cca_cmp u_cca (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cca_active(cca_active),
        .rssi_level(rssi_level),
        .threshold(st.cfg.energy_busy_threshold),
        .channel_busy(channel_busy)
    );

    rcr_batt_mon u_bat (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .monitor_on(st.cfg.battery_monitor_on),
        .trip_level(st.cfg.battery_trip_level),
        .supply_below_trip(supply_below_trip),
        .battery_low_flag(battery_low_flag),
        .trip_cv(battery_trip_cv)
    );

    assign r_chan = st.bank[RCR_SEL_CHAN];
    assign r_txp = st.bank[RCR_SEL_TXP];
    assign r_frb = st.bank[RCR_SEL_FRB];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [RCR_AW-1:0] a);
        psel && penable && pready && pwrite && pstrb[RCR_LANE0]
            && !pslverr && ce && paddr == a;
    endsequence

    sequence s_rd_setup(logic [RCR_AW-1:0] a);
        psel && !penable && !pwrite && ce && paddr == a;
    endsequence

    property p_cca_rst;
        @(posedge pclk) disable iff (1'b0)
        !presetn |-> cfg.energy_busy_threshold == RCR_RST;
    endproperty
    a_cca_rst: assert property (p_cca_rst) // R2
        else $error("threshold not zero in reset");

    property p_cca_wr;
        s_wr(RCR_A_CCA) |=>
            cfg.energy_busy_threshold == $past(pwdata[7:0]);
    endproperty
    a_cca_wr: assert property (p_cca_wr) // R2
        else $error("threshold write lost");

    // derived fields still show the reset image one edge after release
    property p_chan_map;
        $past(presetn) |->
        cfg.channel_mhz == RCR_MHZ_BASE
            + 12'(RCR_MHZ_STEP * 12'(cfg.channel_code))
        && cfg.channel_number == RCR_CH_FIRST + 5'(cfg.channel_code);
    endproperty
    a_chan_map: assert property (p_chan_map) // R3
        else $error("channel mapping wrong");

    property p_chan_wr;
        s_wr(RCR_A_CHAN) |=>
            cfg.channel_code == $past(pwdata[7:4])
            && cfg.rf_optimise_field == $past(pwdata[3:0]);
    endproperty
    a_chan_wr: assert property (p_chan_wr) // R4
        else $error("channel register write lost");

    property p_vco_wr;
        s_wr(RCR_A_VCO) |=>
            cfg.vco_optimise_field == $past(pwdata[7:0]);
    endproperty
    a_vco_wr: assert property (p_vco_wr) // R5
        else $error("vco write lost");

    property p_pll_wr;
        s_wr(RCR_A_PLL) |=>
            cfg.synth_enable == $past(pwdata[7]);
    endproperty
    a_pll_wr: assert property (p_pll_wr) // R6
        else $error("pll enable write lost");

    property p_resv_zero;
        r_txp[2:0] == 3'h0 && r_frb[6:5] == 2'h0
            && r_frb[2:0] == 3'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero) // R7
        else $error("reserved bit stored");

    property p_coarse_30;
        cfg.tx_atten_coarse == 2'h3 && cfg.tx_atten_fine == 3'h0
            |-> cfg.tx_atten_tdb == 9'h12C;
    endproperty
    a_coarse_30: assert property (p_coarse_30) // R8
        else $error("coarse attenuation wrong");

    property p_fine_max;
        cfg.tx_atten_coarse == 2'h0 && cfg.tx_atten_fine == 3'h7
            |-> cfg.tx_atten_tdb == 9'h03F;
    endproperty
    a_fine_max: assert property (p_fine_max) // R9
        else $error("fine attenuation wrong");

    property p_rxs_rd;
        s_rd_setup(RCR_A_RXS) |=>
            prdata == {26'h0, $past(battery_low_flag), 5'h00}
            && pready && !pslverr;
    endproperty
    a_rxs_rd: assert property (p_rxs_rd) // R11
        else $error("status read wrong");

    property p_frb_wr;
        s_wr(RCR_A_FRB) |=>
            cfg.battery_monitor_on == $past(pwdata[3])
            && cfg.tx_filter_on == $past(pwdata[7]);
    endproperty
    a_frb_wr: assert property (p_frb_wr) // R12 R13
        else $error("control 6 write lost");

    property p_wake;
        $past(presetn) |->
        cfg.wake_limit_ms == (r_frb[RCR_WAKE_BIT]
            ? RCR_WAKE_FAST_MS : RCR_WAKE_SLOW_MS);
    endproperty
    a_wake: assert property (p_wake) // R14
        else $error("wake limit wrong");

    property p_mon_gate;
        // a frozen edge keeps an old flag, so only enabled edges count
        (ce && !cfg.battery_monitor_on) |=> !battery_low_flag;
    endproperty
    a_mon_gate: assert property (p_mon_gate) // R15
        else $error("low flag with monitor off");

    property p_unmapped;
        psel && !penable && ce
            && paddr == rcr_baddr(10'h204) |=> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_chan_hold;
        (ce && !(psel && penable && pwrite)) |=>
            r_chan == $past(r_chan);
    endproperty
    a_chan_hold: assert property (p_chan_hold) // R3
        else $error("channel changed without write");

endmodule : rcr_top

// file: tb/tb_top.sv
// Purpose: self-checking bench for the radio config register bank
// Assumes: all bus sampling on rising pclk, waits end on pready
// Notes: random data from an lfsr seeded at 60
`timescale 1ns/1ns
module tb_top
    import rcr_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [RCR_AW-1:0] paddr = '0;
    logic [RCR_DW-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [RCR_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic cca_active = 1'b0;
    logic [7:0] rssi_level = 8'h00;
    logic supply_below_trip = 1'b0;
    rcr_cfg_t cfg;
    logic channel_busy;
    logic battery_low_flag;
    logic [8:0] battery_trip_cv;
    int errors = 0;
    int comparisons = 0;
    logic [15:0] lfsr = 16'h003C;
    logic [31:0] rd;
    logic er;
    logic [RCR_AW-1:0] addr_tab [7];
    logic [7:0] mask_tab [7];
    logic [7:0] model [7];

    rcr_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cca_active(cca_active),
        .rssi_level(rssi_level), .supply_below_trip(supply_below_trip),
        .cfg(cfg), .channel_busy(channel_busy),
        .battery_low_flag(battery_low_flag),
        .battery_trip_cv(battery_trip_cv));

    always #5 pclk = ~pclk;

    function logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    function automatic logic [8:0] exp_tdb(input logic [7:0] v);
        logic [8:0] f;
        case (v[5:3])
            3'h1: f = 9'h005;
            3'h2: f = 9'h00C;
            3'h3: f = 9'h013;
            3'h4: f = 9'h01C;
            3'h5: f = 9'h025;
            3'h6: f = 9'h031;
            3'h7: f = 9'h03F;
            default: f = 9'h000;
        endcase
        return 9'(v[7:6]) * 9'h064 + f;
    endfunction : exp_tdb

    function automatic logic [8:0] exp_cv(input logic [3:0] c);
        logic [8:0] t [16];
        t = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000,
            9'h0FA, 9'h104, 9'h10E, 9'h118, 9'h136, 9'h140, 9'h14A,
            9'h15E, 9'h000};
        return t[c];
    endfunction : exp_cv

    task automatic chk_bus(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bus

    task automatic chk_out(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_out

    // entered and left just after a rising edge, idle cycle at the end
    task automatic apb(input logic wr, input logic [RCR_AW-1:0] a,
            input logic [7:0] d, input logic [3:0] st);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr_reg(input int i, input logic [7:0] d);
        apb(1'b1, addr_tab[i], d, 4'hF);
        chk_bus("write error", 32'h0, {31'h0, er});
        model[i] = d & mask_tab[i];
    endtask : wr_reg

    task automatic rd_reg(input int i);
        apb(1'b0, addr_tab[i], 8'h00, 4'h0);
        chk_bus("read data", {24'h0, model[i]}, rd);
        chk_bus("read error", 32'h0, {31'h0, er});
    endtask : rd_reg

    task automatic chk_cfg();
        logic [3:0] ch;
        ch = model[1][7:4];
        @(negedge pclk);
        chk_out("threshold", model[0], cfg.energy_busy_threshold);
        chk_out("chan code", ch, cfg.channel_code);
        chk_out("chan num", 5'h0B + 5'(ch), cfg.channel_number);
        chk_out("mhz", 12'h965 + 12'(ch) * 5, cfg.channel_mhz);
        chk_out("rf opt", model[1][3:0], cfg.rf_optimise_field);
        chk_out("vco opt", model[2], cfg.vco_optimise_field);
        chk_out("synth", model[3][7], cfg.synth_enable);
        chk_out("coarse", model[4][7:6], cfg.tx_atten_coarse);
        chk_out("fine", model[4][5:3], cfg.tx_atten_fine);
        chk_out("atten", exp_tdb(model[4]), cfg.tx_atten_tdb);
        chk_out("filter", model[6][7], cfg.tx_filter_on);
        chk_out("wake", model[6][4], cfg.fast_wake_recovery);
        chk_out("wake ms", model[6][4] ? 1 : 3, cfg.wake_limit_ms);
        chk_out("bat on", model[6][3], cfg.battery_monitor_on);
        chk_out("trip", model[5][7:4], cfg.battery_trip_level);
        chk_out("trip cv", exp_cv(model[5][7:4]), battery_trip_cv);
        @(posedge pclk);
    endtask : chk_cfg

    task automatic cca(input logic a, input logic [7:0] r);
        cca_active <= a;
        rssi_level <= r;
        @(posedge pclk);
        @(negedge pclk);
        chk_out("busy", a && (r > model[0]), channel_busy);
        @(posedge pclk);
    endtask : cca

    task automatic print_verdict();
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end

    initial begin
        logic f;
        int k;
        addr_tab = '{RCR_A_CCA, RCR_A_CHAN, RCR_A_VCO, RCR_A_PLL,
            RCR_A_TXP, RCR_A_BAT, RCR_A_FRB};
        mask_tab = '{8'hFF, 8'hFF, 8'hFF, 8'h80, 8'hF8, 8'hF0, 8'h98};
        model = '{default: 8'h00};
        // a real falling edge so the bank is cleared before the first clock
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_cfg();
        for (int i = 0; i < 7; i++) rd_reg(i);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wr_reg(1, {i[3:0], 4'h3});
            chk_cfg();
        end
        for (int i = 0; i < 32; i++) begin
            wr_reg(4, {i[4:0], 3'h0});
            chk_cfg();
        end
        for (int i = 0; i < 16; i++) begin
            wr_reg(5, {i[3:0], 4'h0});
            chk_cfg();
        end
        for (int i = 0; i < 16; i++) begin
            wr_reg(6, {i[2], 2'h0, i[1], i[0], 3'h0});
            wr_reg(3, {i[3], 7'h00});
            chk_cfg();
        end
        $display("test field codes done");
        for (int i = 0; i < 40; i++) begin
            k = rnd() % 7;
            wr_reg(k, rnd() & mask_tab[k]);
            rd_reg(rnd() % 7);
            chk_cfg();
        end
        $display("test random access done");
        apb(1'b0, rcr_baddr(10'h204), 8'h00, 4'h0);
        chk_bus("unmapped error", 32'h1, {31'h0, er});
        apb(1'b1, RCR_A_RXS, 8'hFF, 4'hF);
        chk_bus("status write error", 32'h1, {31'h0, er});
        apb(1'b1, addr_tab[2], ~model[2], 4'h0);
        rd_reg(2);
        $display("test refusals done");
        wr_reg(0, 8'h60);
        cca(1'b1, 8'h60);
        cca(1'b1, 8'h61);
        cca(1'b0, 8'hFF);
        cca(1'b1, 8'h5F);
        for (int i = 0; i < 20; i++) cca(rnd() > 8'h40, rnd());
        cca(1'b1, 8'hFF);
        ce <= 1'b0;
        rssi_level <= 8'h00;
        repeat (3) @(posedge pclk);
        chk_out("frozen busy", 1'b1, channel_busy);
        ce <= 1'b1;
        cca(1'b1, 8'h00);
        cca_active <= 1'b0;
        $display("test busy decision done");
        for (int i = 0; i < 16; i++) begin
            k = (i[3:2] == 2'h0) ? 6 : (i[3:2] == 2'h1) ? 7 :
                (i[3:2] == 2'h2) ? 14 : 15;
            wr_reg(6, {4'h0, i[0], 3'h0});
            wr_reg(5, {k[3:0], 4'h0});
            supply_below_trip <= i[1];
            repeat (2) @(posedge pclk);
            f = i[0] && i[1] && k >= 7 && k <= 14;
            @(negedge pclk);
            chk_out("low flag", f, battery_low_flag);
            @(posedge pclk);
            apb(1'b0, RCR_A_RXS, 8'h00, 4'h0);
            chk_bus("status", {26'h0, f, 5'h00}, rd);
        end
        $display("test battery monitor done");
        print_verdict();
    end
endmodule : tb_top
